// >>> shared/sfp_map.vh
// Command codes, status layout, protect limits and timing for the serial flash front end.
`ifndef SFP_MAP_VH
`define SFP_MAP_VH

// Operation codes.
`define SFP_OP_WR_ENABLE     8'h06
`define SFP_OP_WR_DISABLE    8'h04
`define SFP_OP_VOL_ENABLE    8'h50
`define SFP_OP_STATUS_READ   8'h05
`define SFP_OP_STATUS_WRITE  8'h01
`define SFP_OP_READ          8'h03
`define SFP_OP_FAST_READ     8'h0B
`define SFP_OP_DUAL_OUT_READ 8'h3B
`define SFP_OP_DUAL_IO_READ  8'hBB
`define SFP_OP_PAGE_ERASE    8'h81
`define SFP_OP_ERASE_4K      8'h20
`define SFP_OP_HALF_ERASE    8'h52
`define SFP_OP_BLOCK_ERASE   8'hD8
`define SFP_OP_CHIP_ERASE_A  8'h60
`define SFP_OP_CHIP_ERASE_B  8'hC7
`define SFP_OP_PAGE_PROGRAM  8'h02
`define SFP_OP_SEC_ERASE     8'h44
`define SFP_OP_SEC_PROGRAM   8'h42
`define SFP_OP_SEC_READ      8'h48
`define SFP_OP_POWER_DOWN    8'hB9
`define SFP_OP_RELEASE       8'hAB
`define SFP_OP_ID_READ       8'h90
`define SFP_OP_DUAL_ID_READ  8'h92
`define SFP_OP_JEDEC_READ    8'h9F
`define SFP_OP_RST_ENABLE    8'h66
`define SFP_OP_RST           8'h99
`define SFP_OP_UNIQUE_ID     8'h4B

// Status register bit positions.
`define SFP_ST_LOCK   7
`define SFP_ST_SEC2   6
`define SFP_ST_SEC1   5
`define SFP_ST_SEL_HI 4
`define SFP_ST_SEL_LO 2
`define SFP_ST_WEL    1
`define SFP_ST_BUSY   0
`define SFP_ST_RESET  8'h00

// First unprotected address per protect-select code, large density.
`define SFP_LIM1M_1 24'h01E000
`define SFP_LIM1M_2 24'h01C000
`define SFP_LIM1M_3 24'h018000
`define SFP_LIM1M_4 24'h010000
// First unprotected address per protect-select code, small density.
`define SFP_LIM512_1 24'h00E000
`define SFP_LIM512_2 24'h00C000
`define SFP_LIM512_3 24'h008000

// Clock-phase thresholds in serial clocks since chip select fell.
`define SFP_OPCODE_BITS 11'd8
`define SFP_ADDR_END    11'd32
`define SFP_FAST_DATA   11'd40
`define SFP_DUAL_IO_DATA 11'd24

// Busy times in 200 MHz clocks: 2 ms program, 15 ms erase, 5 ms status write.
// Held as 24-bit counts so they load the busy timer without truncation.
`define SFP_PROG_CYCLES  24'h061A80
`define SFP_ERASE_CYCLES 24'h2DC6C0
`define SFP_STWR_CYCLES  24'h0F4240

`endif

// >>> design/sfp_core.v
// Serial flash command front end with status register and write protection.
//
// Functional notes
// (R1) Unknown opcode: stay standby until next chip select fall, output lines released.
// (R2) Known opcode: active mode until chip select rises.
// (R3) Sample input on rising serial clock, shift output on falling edge.
// (R4) Serial clock may idle low or high; only edges after select fall count.
// (R5) Dual commands use both data lines, two bits per clock; the code enables both lines but moves one bit per clock, line 0 driving zero.
// (R6) Status bits: lock, security two, security one, three selects, latch, busy.
// (R7) Busy reads one while program, erase or status write runs.
// (R8) Latch clear refuses status write, program and erase.
// (R9) Protect selects change only by status write and shield an array region.
// (R10) Program and erase inside the shielded region are rejected.
// (R11) Protect selects writable only outside hardware protected mode.
// (R12) Chip erase runs only when all protect selects are zero.
// (R13) Protect selects come up zero.
// (R14) Lock bit set with write-protect low blocks status writes.
// (R15) Lock bit comes up zero.
// (R16) Security lock bits are set-only and lock their security registers.
// (R17) Command machine starts in standby at power up.
// (R18) Commands accepted only if whole bytes, ending on byte boundary.
// (R19) Write enable command sets latch; modifying commands need it.
// (R20) In deep power-down only the release command is honoured.
// (R21) Large density select decode: none, 30, 28, 24, 16 of 32, then all.
// (R22) Small density select decode: none, 14, 12, 8 of 16, then all.
// (R23) Modifying and power-down commands need chip select high on byte boundary.
// (R24) Each command opens with one opcode byte, most significant bit first.
// (R25) Build-time density parameter picks the protect decode.
// (R26) Latch clears when an accepted modifying operation completes.
// (R27) Program or erase while busy is rejected.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_map.vh"

module sfp_core #(
	parameter        IS_1MBIT     = 1,
	parameter [23:0] PROG_CYCLES  = `SFP_PROG_CYCLES,
	parameter [23:0] ERASE_CYCLES = `SFP_ERASE_CYCLES,
	parameter [23:0] STWR_CYCLES  = `SFP_STWR_CYCLES
) (
	// Clock and reset.
	input  wire        clock,
	input  wire        rst_n,
	// Serial pins from the host.
	input  wire        csN,
	input  wire        sclk,
	input  wire        wpN,
	// Data line 0: serial input, second dual line.
	input  wire        dualLine0In,
	output reg         dualLine0Out,
	output reg         dualLine0Oe,
	// Data line 1: serial output, first dual line.
	input  wire        dualLine1In,
	output reg         dualLine1Out,
	output reg         dualLine1Oe,
	// Array side.
	output reg         opStartQ,
	output reg  [7:0]  opCodeQ,
	output reg  [23:0] opAddrQ,
	output reg         deepPowerDownQ,
	output wire [1:0]  securityLock
);

	localparam [3:0] ST_STANDBY = 4'h1;
	localparam [3:0] ST_OPCODE  = 4'h2;
	localparam [3:0] ST_ACTIVE  = 4'h4;
	localparam [3:0] ST_IGNORE  = 4'h8;

	// Two-stage synchronisers plus a third stage for edge detection.
	reg  [1:0] csSync, clkSync, wpSync, in0Sync;
	reg        csPrev, clkPrev;
	wire       csRise = csSync[1] & ~csPrev;
	wire       csFall = ~csSync[1] & csPrev;
	wire       sckRise = clkSync[1] & ~clkPrev & ~csSync[1];
	wire       sckFall = ~clkSync[1] & clkPrev & ~csSync[1];

	reg  [3:0]  stateQ;
	reg  [10:0] bitCntQ;
	reg  [31:0] shiftQ;
	reg  [7:0]  opQ;
	reg         statusLockQ, sec2Q, sec1Q, welQ, busyQ;
	reg  [2:0]  protSelQ;
	reg  [23:0] busyCntQ;
	wire [7:0]  statusWord = {statusLockQ, sec2Q, sec1Q, protSelQ, welQ, busyQ}; // [R6]
	wire [7:0]  opNext = {shiftQ[6:0], in0Sync[1]};
	wire        hwProt = statusLockQ & ~wpSync[1];
	assign securityLock = {sec2Q, sec1Q}; // [R16]

	// Whether an opcode starts a known command; during power-down only release counts.
	function known;
		input [7:0] op;
		input       dpd;
		begin
			if (dpd)
				known = (op == `SFP_OP_RELEASE); // [R20]
			else begin
				case (op)
					`SFP_OP_WR_ENABLE, `SFP_OP_WR_DISABLE, `SFP_OP_VOL_ENABLE,
					`SFP_OP_STATUS_READ, `SFP_OP_STATUS_WRITE, `SFP_OP_READ,
					`SFP_OP_FAST_READ, `SFP_OP_DUAL_OUT_READ, `SFP_OP_DUAL_IO_READ,
					`SFP_OP_PAGE_ERASE, `SFP_OP_ERASE_4K, `SFP_OP_HALF_ERASE,
					`SFP_OP_BLOCK_ERASE, `SFP_OP_CHIP_ERASE_A, `SFP_OP_CHIP_ERASE_B,
					`SFP_OP_PAGE_PROGRAM, `SFP_OP_SEC_ERASE, `SFP_OP_SEC_PROGRAM,
					`SFP_OP_SEC_READ, `SFP_OP_POWER_DOWN, `SFP_OP_RELEASE,
					`SFP_OP_ID_READ, `SFP_OP_DUAL_ID_READ, `SFP_OP_JEDEC_READ,
					`SFP_OP_RST_ENABLE, `SFP_OP_RST, `SFP_OP_UNIQUE_ID: known = 1'b1;
					default: known = 1'b0;
				endcase
			end
		end
	endfunction

	// Protected-region test; the same select field serves both densities.
	function protHit;
		input [2:0]  sel;
		input [23:0] a;
		begin
			if (IS_1MBIT != 0) begin // [R25]
				case (sel) // [R21]
					3'h0:    protHit = 1'b0;
					3'h1:    protHit = (a < `SFP_LIM1M_1);
					3'h2:    protHit = (a < `SFP_LIM1M_2);
					3'h3:    protHit = (a < `SFP_LIM1M_3);
					3'h4:    protHit = (a < `SFP_LIM1M_4);
					default: protHit = 1'b1;
				endcase
			end else begin
				case (sel) // [R22]
					3'h0:    protHit = 1'b0;
					3'h1:    protHit = (a < `SFP_LIM512_1);
					3'h2:    protHit = (a < `SFP_LIM512_2);
					3'h3:    protHit = (a < `SFP_LIM512_3);
					default: protHit = 1'b1;
				endcase
			end
		end
	endfunction

	// Pins cross from the host's domain; nothing reads the first stage directly.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			csSync  <= 2'h3;
			clkSync <= 2'h0;
			wpSync  <= 2'h3;
			in0Sync <= 2'h0;
			csPrev  <= 1'b1;
			clkPrev <= 1'b0;
		end else begin
			csSync  <= {csSync[0], csN};
			clkSync <= {clkSync[0], sclk};
			wpSync  <= {wpSync[0], wpN};
			in0Sync <= {in0Sync[0], dualLine0In};
			csPrev  <= csSync[1];
			clkPrev <= clkSync[1];
		end
	end

	// Line 1 is never read as an input here since dual input phases carry only address.
	wire unusedIn1 = dualLine1In;

	// Decisions taken when chip select rises on an active command.
	wire       wholeBytes = (bitCntQ[2:0] == 3'h0);
	wire [7:0] nBytes = bitCntQ[10:3];
	wire       isErase = (opQ == `SFP_OP_PAGE_ERASE) | (opQ == `SFP_OP_ERASE_4K) |
	                     (opQ == `SFP_OP_HALF_ERASE) | (opQ == `SFP_OP_BLOCK_ERASE);
	wire       isChip = (opQ == `SFP_OP_CHIP_ERASE_A) | (opQ == `SFP_OP_CHIP_ERASE_B);
	wire       isProg = (opQ == `SFP_OP_PAGE_PROGRAM);
	wire       modOk = welQ & ~busyQ; // [R8] [R19] [R27]
	wire       doErase = isErase & (nBytes == 8'd4) & modOk & ~protHit(protSelQ, opAddrQ); // [R10]
	wire       doChip = isChip & (nBytes == 8'd1) & modOk & (protSelQ == 3'h0); // [R12]
	wire       doProg = isProg & (nBytes >= 8'd5) & modOk & ~protHit(protSelQ, opAddrQ); // [R10]
	wire       doStWr = (opQ == `SFP_OP_STATUS_WRITE) & (nBytes == 8'd2) & modOk & ~hwProt; // [R14]
	wire       execNow = csRise & (stateQ == ST_ACTIVE) & wholeBytes; // [R18] [R23]

	// Command sequencer; the reset state is standby.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stateQ  <= ST_STANDBY; // [R17]
			bitCntQ <= 11'h000;
			shiftQ  <= 32'h00000000;
			opQ     <= 8'h00;
		end else if (csRise) begin
			stateQ <= ST_STANDBY; // [R2]
		end else if (csFall) begin
			stateQ  <= ST_OPCODE; // [R4]
			bitCntQ <= 11'h000;
		end else if (sckRise && stateQ != ST_STANDBY) begin
			// Counter sticks in its top bit so long payloads keep a valid byte phase.
			bitCntQ <= {bitCntQ[10] | (&bitCntQ[9:0]), bitCntQ[9:0] + 10'h001};
			shiftQ  <= {shiftQ[30:0], in0Sync[1]}; // [R3] [R24]
			case (stateQ)
				ST_OPCODE: begin
					if (bitCntQ == `SFP_OPCODE_BITS - 11'd1) begin
						opQ    <= opNext;
						stateQ <= known(opNext, deepPowerDownQ) ? ST_ACTIVE : ST_IGNORE; // [R1] [R2]
					end
				end
				ST_ACTIVE: stateQ <= ST_ACTIVE;
				ST_IGNORE: stateQ <= ST_IGNORE;
				default:   stateQ <= ST_STANDBY;
			endcase
		end
	end

	// Address latch once three address bytes are in.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			opAddrQ <= 24'h000000;
		end else if (stateQ == ST_ACTIVE && bitCntQ == `SFP_ADDR_END && !sckRise) begin
			opAddrQ <= shiftQ[23:0];
		end
	end

	// Status bits, power-down flag and the busy timer.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			statusLockQ    <= 1'b0; // [R15]
			sec2Q          <= 1'b0;
			sec1Q          <= 1'b0;
			protSelQ       <= 3'h0; // [R13]
			welQ           <= 1'b0;
			busyQ          <= 1'b0;
			busyCntQ       <= 24'h000000;
			deepPowerDownQ <= 1'b0;
			opStartQ       <= 1'b0;
			opCodeQ        <= 8'h00;
		end else begin
			opStartQ <= 1'b0;
			if (busyQ) begin
				if (busyCntQ <= 24'h000001) begin
					busyQ <= 1'b0; // [R7]
					welQ  <= 1'b0; // [R26]
				end
				busyCntQ <= busyCntQ - 24'h000001;
			end
			if (execNow) begin
				if (opQ == `SFP_OP_WR_ENABLE && nBytes == 8'd1)
					welQ <= 1'b1; // [R19]
				if (opQ == `SFP_OP_WR_DISABLE && nBytes == 8'd1)
					welQ <= 1'b0;
				if (opQ == `SFP_OP_POWER_DOWN && nBytes == 8'd1 && !busyQ)
					deepPowerDownQ <= 1'b1; // [R20]
				if (opQ == `SFP_OP_RELEASE)
					deepPowerDownQ <= 1'b0;
				if (doStWr) begin
					statusLockQ <= shiftQ[`SFP_ST_LOCK];
					protSelQ    <= shiftQ[`SFP_ST_SEL_HI:`SFP_ST_SEL_LO]; // [R9] [R11]
					sec2Q       <= sec2Q | shiftQ[`SFP_ST_SEC2]; // [R16]
					sec1Q       <= sec1Q | shiftQ[`SFP_ST_SEC1];
				end
				if (doStWr || doErase || doChip || doProg) begin
					busyQ    <= 1'b1; // [R7]
					busyCntQ <= doProg ? PROG_CYCLES : (doStWr ? STWR_CYCLES : ERASE_CYCLES);
					opStartQ <= ~doStWr;
					opCodeQ  <= opQ;
				end
			end
		end
	end

	// Output phase thresholds per command; zero means the command never drives data.
	reg [10:0] outStart;
	reg        outDual;
	always @* begin
		outStart = 11'h000;
		outDual  = 1'b0;
		case (opQ)
			`SFP_OP_STATUS_READ: outStart = `SFP_OPCODE_BITS;
			`SFP_OP_READ:        outStart = `SFP_ADDR_END;
			`SFP_OP_FAST_READ:   outStart = `SFP_FAST_DATA;
			`SFP_OP_DUAL_OUT_READ: begin
				outStart = `SFP_FAST_DATA;
				outDual  = 1'b1; // [R5]
			end
			`SFP_OP_DUAL_IO_READ, `SFP_OP_DUAL_ID_READ: begin
				outStart = `SFP_DUAL_IO_DATA;
				outDual  = 1'b1; // [R5]
			end
			default: outStart = 11'h000;
		endcase
	end

	// Output lines change on falling serial clock; array data itself lies outside
	// this block, so data phases other than status shift zeros.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dualLine0Out <= 1'b0;
			dualLine0Oe  <= 1'b0;
			dualLine1Out <= 1'b0;
			dualLine1Oe  <= 1'b0;
		end else if (stateQ != ST_ACTIVE || csSync[1]) begin
			dualLine0Oe <= 1'b0; // [R1]
			dualLine1Oe <= 1'b0;
		end else if (sckFall && outStart != 11'h000 && bitCntQ >= outStart) begin
			dualLine1Oe  <= 1'b1; // [R3]
			dualLine0Oe  <= outDual;
			dualLine1Out <= (opQ == `SFP_OP_STATUS_READ) ?
			                statusWord[3'h7 - bitCntQ[2:0]] : 1'b0;
			dualLine0Out <= 1'b0;
		end
	end

endmodule // sfp_core

`default_nettype wire

// >>> tb/sfp_core_checker.sv
// Concurrent checks on the pins of the serial flash front end.
`timescale 1ns/1ps
`default_nettype none
module sfp_core_checker (
	// Clock and reset.
	input wire logic        clock,
	input wire logic        rst_n,
	// Host pins.
	input wire logic        csN,
	input wire logic        sclk,
	// Device outputs.
	input wire logic        dualLine0Oe,
	input wire logic        dualLine1Out,
	input wire logic        dualLine1Oe,
	input wire logic        opStartQ,
	input wire logic [23:0] opAddrQ,
	input wire logic        deepPowerDownQ,
	input wire logic [1:0]  securityLock
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// A deselected device leaves both lines floating after its synchroniser delay.
	idle_release_a: assert property (csN[*6] |-> !dualLine1Oe && !dualLine0Oe)
		else $error("line driven while deselected");
	dual_pair_a: assert property (dualLine0Oe |-> dualLine1Oe)
		else $error("line 0 driven alone");
	// The serial clock pin three edges back must already be low when data moves.
	out_on_fall_a: assert property (dualLine1Oe && $past(dualLine1Oe) && $changed(dualLine1Out)
		|-> !$past(sclk, 3))
		else $error("output moved outside the low clock phase");
	start_deselect_a: assert property (opStartQ |-> csN)
		else $error("operation started while selected");
	start_single_a: assert property (opStartQ |=> !opStartQ)
		else $error("start pulse longer than one cycle");
	sleep_no_op_a: assert property (deepPowerDownQ |-> !opStartQ)
		else $error("operation started in power-down");
	sleep_edge_a: assert property ($changed(deepPowerDownQ) |-> csN)
		else $error("power-down changed mid-frame");
	lock_keep_a: assert property (!$fell(securityLock[0]) && !$fell(securityLock[1]))
		else $error("security lock cleared");
	addr_hold_a: assert property (csN[*8] |-> $stable(opAddrQ))
		else $error("address moved while deselected");
endmodule // sfp_core_checker
bind sfp_core sfp_core_checker i_chk (.clock(clock), .rst_n(rst_n), .csN(csN), .sclk(sclk),
	.dualLine0Oe(dualLine0Oe), .dualLine1Out(dualLine1Out), .dualLine1Oe(dualLine1Oe),
	.opStartQ(opStartQ), .opAddrQ(opAddrQ), .deepPowerDownQ(deepPowerDownQ),
	.securityLock(securityLock));
`default_nettype wire

// >>> tb/sfp_host_model.sv
// Behavioural host that drives frames onto the serial pins.
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model (
	// Bench clock, used only to place frames relative to its edges.
	input  wire logic clock,
	// Serial pins.
	output logic      csN,
	output logic      sclk,
	output logic      mosi,
	input  wire logic miso
);
	// Deselected with the clock standing still.
	initial begin
		csN = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	// One frame of nb bits, MSB first; the line is sampled just before each fall.
	// Pin changes after the first sit on whole-nanosecond times, so none lands on a sampling edge.
	task automatic xfer(input int nb, input logic [63:0] dout, input bit cpol,
		output logic [63:0] din);
		din = '0;
		@(posedge clock) #1 sclk = cpol;
		#29.5 csN = 1'b0;
		#24;
		for (int i = nb - 1; i >= 0; i--) begin
			sclk = 1'b0;
			mosi = dout[i];
			#24 sclk = 1'b1;
			#24 din = {din[62:0], miso};
		end
		#6 sclk = cpol;
		#6 csN = 1'b1;
		// A released line shows the inverse, so a stale bit never looks valid.
		mosi = ~mosi;
		#40;
	endtask
endmodule // sfp_host_model
`default_nettype wire

// >>> tb/sfp_core_tb.sv
// Self-checking bench for the serial flash front end.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_map.vh"
module sfp_core_tb;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        wpN = 1'b1;
	logic        csN, sclk, mosi, o0, e0, o1, e1, op, dpd, op5;
	logic        seenClr = 1'b0;
	logic [7:0]  opc, st;
	logic [23:0] adr;
	logic [1:0]  sec, seen;
	logic [63:0] rx;
	int          fails = 0, checked = 0, cyc = 0, starts = 0, starts5 = 0;
	// Undriven line 1 follows the serial clock so it never holds a stale bit.
	wire         line1 = e1 ? o1 : sclk;
	always #2.5 clock = ~clock;
	// Short array times keep the run small.
	sfp_core #(.IS_1MBIT(1), .PROG_CYCLES(24'd400), .ERASE_CYCLES(24'd400),
		.STWR_CYCLES(24'd400)) i_dut (.clock(clock), .rst_n(rst_n), .csN(csN),
		.sclk(sclk), .wpN(wpN), .dualLine0In(e0 ? o0 : mosi), .dualLine0Out(o0),
		.dualLine0Oe(e0), .dualLine1In(line1), .dualLine1Out(o1), .dualLine1Oe(e1),
		.opStartQ(op), .opCodeQ(opc), .opAddrQ(adr), .deepPowerDownQ(dpd),
		.securityLock(sec));
	// Small-density copy on the same pins; only its start pulse is watched.
	sfp_core #(.IS_1MBIT(0), .PROG_CYCLES(24'd400), .ERASE_CYCLES(24'd400),
		.STWR_CYCLES(24'd400)) i_dut512 (.clock(clock), .rst_n(rst_n), .csN(csN),
		.sclk(sclk), .wpN(wpN), .dualLine0In(mosi), .dualLine0Out(),
		.dualLine0Oe(), .dualLine1In(1'b0), .dualLine1Out(), .dualLine1Oe(),
		.opStartQ(op5), .opCodeQ(), .opAddrQ(), .deepPowerDownQ(),
		.securityLock());
	sfp_host_model i_host (.clock(clock), .csN(csN), .sclk(sclk), .mosi(mosi),
		.miso(line1));
	// Cycle ceiling, start pulse count and drive watch.
	always @(posedge clock) begin
		cyc++;
		if (op === 1'b1) starts++;
		if (op5 === 1'b1) starts5++;
		seen <= seenClr ? 2'b00 : (seen | {e0, e1});
		if (cyc == 60000) begin
			fails++;
			close_out();
		end
	end
	task automatic chk(input logic [23:0] got, exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input int nb, input logic [63:0] v);
		i_host.xfer(nb, v, 1'b0, rx);
	endtask
	task automatic rdst(input bit m3);
		i_host.xfer(16, {`SFP_OP_STATUS_READ, 8'h00}, m3, rx);
		st = rx[7:0];
	endtask
	// Polls status until idle, with a bounded number of reads.
	task automatic idle();
		rdst(0);
		for (int k = 0; k < 30 && st[0] !== 1'b0; k++) rdst(0);
		chk(st[0], 1'b0);
	endtask
	task automatic wrst(input logic [7:0] v);
		cmd(8, `SFP_OP_WR_ENABLE);
		cmd(16, {`SFP_OP_STATUS_WRITE, v});
		idle();
	endtask
	task automatic t_basic();
		rdst(1);
		chk(st, 8'h00);
		cmd(8, `SFP_OP_WR_ENABLE);
		rdst(0);
		chk(st, 8'h02);
		cmd(7, 8'h02);
		rdst(0);
		chk(st, 8'h02);
		cmd(8, `SFP_OP_WR_DISABLE);
		cmd(16, {`SFP_OP_STATUS_WRITE, 8'h0C});
		rdst(0);
		chk(st, 8'h00);
		cmd(8, `SFP_OP_WR_ENABLE);
		cmd(16, {`SFP_OP_STATUS_WRITE, 8'h0C});
		rdst(0);
		chk(st[1:0], 2'b11);
		idle();
		chk(st, 8'h0C);
		$display("test basic done");
	endtask
	// Small density: last protected sector refused, first free sector taken.
	task automatic t_small();
		logic [23:0] lim [3] = '{`SFP_LIM512_1, `SFP_LIM512_2, `SFP_LIM512_3};
		int s;
		for (int c = 1; c <= 4; c++) begin
			wrst(8'(c << 2));
			s = starts5;
			cmd(8, `SFP_OP_WR_ENABLE);
			cmd(32, {`SFP_OP_ERASE_4K, c < 4 ? lim[c - 1] - 24'h001000 : 24'h00F000});
			repeat (420) @(posedge clock);
			chk(starts5 - s, 0);
			if (c < 4) begin
				cmd(8, `SFP_OP_WR_ENABLE);
				cmd(32, {`SFP_OP_ERASE_4K, lim[c - 1]});
				repeat (420) @(posedge clock);
				chk(starts5 - s, 1);
			end
		end
		$display("test small done");
	endtask
	task automatic t_protect();
		logic [23:0] lim [4] = '{24'h01E000, 24'h01C000, 24'h018000, 24'h010000};
		int s;
		for (int c = 1; c <= 5; c++) begin
			wrst(8'(c << 2));
			s = starts;
			cmd(8, `SFP_OP_WR_ENABLE);
			cmd(40, {`SFP_OP_PAGE_PROGRAM, lim[c % 5 - (c < 5)] - 24'd1, 8'hA5});
			idle();
			chk(starts - s, 0);
			cmd(8, `SFP_OP_WR_ENABLE);
			cmd(32, {`SFP_OP_ERASE_4K, c < 5 ? lim[c - 1] : 24'h01F000});
			idle();
			chk(starts - s, c < 5);
			if (c < 5) chk(adr, lim[c - 1]);
		end
		cmd(8, `SFP_OP_WR_ENABLE);
		cmd(8, `SFP_OP_CHIP_ERASE_A);
		idle();
		chk(starts - s, 0);
		wrst(8'h00);
		cmd(8, `SFP_OP_WR_ENABLE);
		cmd(8, `SFP_OP_CHIP_ERASE_A);
		idle();
		chk(starts - s, 1);
		chk(opc, `SFP_OP_CHIP_ERASE_A);
		chk(st[1], 1'b0);
		$display("test protect done");
	endtask
	task automatic t_lines();
		@(posedge clock) #1 seenClr = 1'b1;
		@(posedge clock) #1 seenClr = 1'b0;
		cmd(16, 16'hFF05);
		chk(seen, 2'b00);
		cmd(48, {`SFP_OP_DUAL_OUT_READ, 40'h0});
		chk(seen, 2'b11);
		cmd(8, `SFP_OP_POWER_DOWN);
		chk(dpd, 1'b1);
		cmd(8, `SFP_OP_WR_ENABLE);
		cmd(8, `SFP_OP_RELEASE);
		chk(dpd, 1'b0);
		rdst(0);
		chk(st[1], 1'b0);
		$display("test lines done");
	endtask
	task automatic t_lock();
		wrst(8'hE0);
		chk(sec, 2'b11);
		@(posedge clock) #1 wpN = 1'b0;
		wrst(8'h00);
		chk(st[7:2], 6'h38);
		@(posedge clock) #1 wpN = 1'b1;
		wrst(8'h00);
		chk(st, 8'h60);
		$display("test lock done");
	endtask
	task automatic close_out();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Reset for five cycles, then the scenarios in turn.
	initial begin
		repeat (5) @(posedge clock);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clock);
		t_basic();
		t_small();
		t_protect();
		t_lines();
		t_lock();
		close_out();
	end
endmodule // sfp_core_tb
`default_nettype wire
